// ### shared/rcrb_pkg.sv
/*
  Package of the regulator configuration register bank: register offsets,
  field positions, reset values, step-rate timing and the carrier structs.
  Assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package rcrb_pkg;

  // Byte offsets of the registers, one aligned word each
  localparam logic [7:0] RCRB_OFF_BKP_A = 8'h00;
  localparam logic [7:0] RCRB_OFF_BKP_B = 8'h04;
  localparam logic [7:0] RCRB_OFF_BKP_C = 8'h08;
  localparam logic [7:0] RCRB_OFF_BKP_D = 8'h0c;
  localparam logic [7:0] RCRB_OFF_A_NORM = 8'h10;
  localparam logic [7:0] RCRB_OFF_A_STBY = 8'h14;
  localparam logic [7:0] RCRB_OFF_A_SLEEP = 8'h18;
  localparam logic [7:0] RCRB_OFF_A_MODE = 8'h1c;
  localparam logic [7:0] RCRB_OFF_A_CONF = 8'h20;
  localparam logic [7:0] RCRB_OFF_B_NORM = 8'h24;
  localparam logic [7:0] RCRB_OFF_B_STBY = 8'h28;
  localparam logic [7:0] RCRB_OFF_B_SLEEP = 8'h2c;
  localparam logic [7:0] RCRB_OFF_B_MODE = 8'h30;
  localparam logic [7:0] RCRB_OFF_A_STEP = 8'h34;

  // Field positions
  localparam int RCRB_VCODE_MSB = 4;
  localparam int RCRB_SWMODE_MSB = 3;
  localparam int RCRB_TURNOFF_BIT = 5;
  localparam int RCRB_RATE_BIT = 6;
  localparam int RCRB_PHASE_LSB = 4;
  localparam int RCRB_FREQ_LSB = 2;
  localparam int RCRB_ILIM_BIT = 0;

  // Backup bytes clear to this on the coin-cell power-on reset
  localparam logic [7:0] RCRB_BKP_RESET = 8'h00;

  // Voltage-step periods, in ns, and their cycle counts at 200 MHz
  localparam int RCRB_CLK_PERIOD_NS = 5;
  localparam int RCRB_STEP_FAST_NS = 2000;
  localparam int RCRB_STEP_SLOW_NS = 4000;
  localparam int RCRB_STEP_FAST_CYC = RCRB_STEP_FAST_NS / RCRB_CLK_PERIOD_NS;
  localparam int RCRB_STEP_SLOW_CYC = RCRB_STEP_SLOW_NS / RCRB_CLK_PERIOD_NS;

  // Settings of one buck channel as driven to the regulator control
  typedef struct packed {
    logic [4:0] norm_code;
    logic [4:0] stby_code;
    logic [4:0] sleep_code;
    logic turnoff_dest;
    logic [3:0] switch_mode;
  } rcrb_chan_t;

  // Configuration fields of channel A
  typedef struct packed {
    logic step_rate;
    logic [1:0] clock_phase;
    logic [1:0] switch_freq;
    logic current_limit;
  } rcrb_conf_t;

  // OTP defaults for the regulator registers, loaded at power-up
  typedef struct packed {
    rcrb_chan_t chan_a;
    rcrb_chan_t chan_b;
    rcrb_conf_t conf_a;
  } rcrb_otp_t;

endpackage

// ### rtl/rcrb_top.sv
/*
  Regulator configuration register bank: four backup memory bytes and the
  settings of buck channels A and B, reached over an AHB-Lite slave.
  Assumes one 200 MHz clock, a synchronous main reset, a separate
  coin-cell power-on reset for the backup bytes and an OTP default word.
*/
// Added by the designer: the AHB-Lite interface to the registers and the address map.
// Behaviour
// - Backup bytes keep their value across main supply loss while coin cell exists.
// - Backup bytes clear only on coin-cell power-on reset, never main reset.
// - Channel A keeps a 5-bit normal voltage code in bits 4:0.
// - Channel A keeps a 5-bit standby voltage code in bits 4:0.
// - Channel A keeps a 5-bit sleep voltage code in bits 4:0.
// - Channel A mode bit 5 picks off or sleep after turn-off.
// - Channel A mode bits 3:0 hold the switching mode code.
// - Channel A conf bit 6 picks step every 2.0 us or 4.0 us.
// - Channel A conf bits 5:4 hold the switching clock phase.
// - Channel A conf bits 3:2 hold the switching frequency.
// - Channel A conf bit 0 picks 2.75 A or 2.0 A limit.
// - Regulator registers are readable and writable at any time; the code drops bus reads and writes while I_CLK_EN is low.
// - Regulator registers take their reset values from OTP.
// - Channel B keeps its own normal, standby and sleep 5-bit codes.
// - Channel B mode has turn-off bit 5 and switching mode 3:0.
`timescale 1ns/100ps
module rcrb_top #(
  parameter int STEP_FAST_CYC = rcrb_pkg::RCRB_STEP_FAST_CYC,
  parameter int STEP_SLOW_CYC = rcrb_pkg::RCRB_STEP_SLOW_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic I_CLK_EN,
  input wire logic I_BACKUP_CELL_POR_N,
  input wire rcrb_pkg::rcrb_otp_t I_OTP_DEFAULTS,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [7:0] O_BACKUP_BYTE_A,
  output logic [7:0] O_BACKUP_BYTE_B,
  output logic [7:0] O_BACKUP_BYTE_C,
  output logic [7:0] O_BACKUP_BYTE_D,
  output rcrb_pkg::rcrb_chan_t O_BUCK_CHANNEL_A,
  output rcrb_pkg::rcrb_chan_t O_BUCK_CHANNEL_B,
  output rcrb_pkg::rcrb_conf_t O_CHAN_A_CONF,
  output logic O_CHAN_A_STEP_TICK
);

  localparam int NBKP = 4;
  localparam int CW = 12;

  // Whole state of the block
  typedef struct packed {
    logic [NBKP-1:0][7:0] bkp;
    rcrb_pkg::rcrb_chan_t chan_a;
    rcrb_pkg::rcrb_chan_t chan_b;
    rcrb_pkg::rcrb_conf_t conf_a;
    logic [CW-1:0] step_cnt;
    logic step_tick;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } rcrb_state_t;

  rcrb_state_t state_r;
  rcrb_state_t state_nxt;
  logic [7:0] rd_byte;
  logic [7:0] wb;
  logic addr_phase;
  logic [CW-1:0] step_limit;

  // Address phase accepted when selected, active and bus ready
  assign addr_phase = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign wb = I_HWDATA[7:0];

  assign step_limit = state_r.conf_a.step_rate ? CW'(STEP_SLOW_CYC - 1) : CW'(STEP_FAST_CYC - 1);

  // Read mux of the register addressed in the address phase
  always_comb begin
    rd_byte = 8'h00;
    unique case (I_HADDR[7:0])
      rcrb_pkg::RCRB_OFF_BKP_A: rd_byte = state_r.bkp[0];
      rcrb_pkg::RCRB_OFF_BKP_B: rd_byte = state_r.bkp[1];
      rcrb_pkg::RCRB_OFF_BKP_C: rd_byte = state_r.bkp[2];
      rcrb_pkg::RCRB_OFF_BKP_D: rd_byte = state_r.bkp[3];
      rcrb_pkg::RCRB_OFF_A_NORM: rd_byte = {3'h0, state_r.chan_a.norm_code};
      rcrb_pkg::RCRB_OFF_A_STBY: rd_byte = {3'h0, state_r.chan_a.stby_code};
      rcrb_pkg::RCRB_OFF_A_SLEEP: rd_byte = {3'h0, state_r.chan_a.sleep_code};
      rcrb_pkg::RCRB_OFF_A_MODE: begin
        rd_byte = {2'h0, state_r.chan_a.turnoff_dest, 1'b0, state_r.chan_a.switch_mode};
      end
      rcrb_pkg::RCRB_OFF_A_CONF: begin
        rd_byte = {1'b0, state_r.conf_a.step_rate, state_r.conf_a.clock_phase,
                   state_r.conf_a.switch_freq, 1'b0, state_r.conf_a.current_limit};
      end
      rcrb_pkg::RCRB_OFF_B_NORM: rd_byte = {3'h0, state_r.chan_b.norm_code};
      rcrb_pkg::RCRB_OFF_B_STBY: rd_byte = {3'h0, state_r.chan_b.stby_code};
      rcrb_pkg::RCRB_OFF_B_SLEEP: rd_byte = {3'h0, state_r.chan_b.sleep_code};
      rcrb_pkg::RCRB_OFF_B_MODE: begin
        rd_byte = {2'h0, state_r.chan_b.turnoff_dest, 1'b0, state_r.chan_b.switch_mode};
      end
      rcrb_pkg::RCRB_OFF_A_STEP: rd_byte = {7'h00, state_r.step_tick};
      default: rd_byte = 8'h00;
    endcase
  end

  // Next state: bus writes, read capture and step timer
  always_comb begin
    state_nxt = state_r;
    state_nxt.wr_pend = addr_phase & I_HWRITE;
    if (addr_phase) begin
      state_nxt.wr_addr = I_HADDR[7:0];
      state_nxt.rdata = I_HWRITE ? 32'h0000_0000 : {24'h000000, rd_byte};
    end
    if (state_r.wr_pend) begin
      unique case (state_r.wr_addr)
        rcrb_pkg::RCRB_OFF_BKP_A: state_nxt.bkp[0] = wb;
        rcrb_pkg::RCRB_OFF_BKP_B: state_nxt.bkp[1] = wb;
        rcrb_pkg::RCRB_OFF_BKP_C: state_nxt.bkp[2] = wb;
        rcrb_pkg::RCRB_OFF_BKP_D: state_nxt.bkp[3] = wb;
        rcrb_pkg::RCRB_OFF_A_NORM: state_nxt.chan_a.norm_code = wb[rcrb_pkg::RCRB_VCODE_MSB:0];
        rcrb_pkg::RCRB_OFF_A_STBY: state_nxt.chan_a.stby_code = wb[rcrb_pkg::RCRB_VCODE_MSB:0];
        rcrb_pkg::RCRB_OFF_A_SLEEP: state_nxt.chan_a.sleep_code = wb[rcrb_pkg::RCRB_VCODE_MSB:0];
        rcrb_pkg::RCRB_OFF_A_MODE: begin
          state_nxt.chan_a.turnoff_dest = wb[rcrb_pkg::RCRB_TURNOFF_BIT];
          state_nxt.chan_a.switch_mode = wb[rcrb_pkg::RCRB_SWMODE_MSB:0];
        end
        rcrb_pkg::RCRB_OFF_A_CONF: begin
          state_nxt.conf_a.step_rate = wb[rcrb_pkg::RCRB_RATE_BIT];
          state_nxt.conf_a.clock_phase = wb[rcrb_pkg::RCRB_PHASE_LSB +: 2];
          state_nxt.conf_a.switch_freq = wb[rcrb_pkg::RCRB_FREQ_LSB +: 2];
          state_nxt.conf_a.current_limit = wb[rcrb_pkg::RCRB_ILIM_BIT];
        end
        rcrb_pkg::RCRB_OFF_B_NORM: state_nxt.chan_b.norm_code = wb[rcrb_pkg::RCRB_VCODE_MSB:0];
        rcrb_pkg::RCRB_OFF_B_STBY: state_nxt.chan_b.stby_code = wb[rcrb_pkg::RCRB_VCODE_MSB:0];
        rcrb_pkg::RCRB_OFF_B_SLEEP: state_nxt.chan_b.sleep_code = wb[rcrb_pkg::RCRB_VCODE_MSB:0];
        rcrb_pkg::RCRB_OFF_B_MODE: begin
          state_nxt.chan_b.turnoff_dest = wb[rcrb_pkg::RCRB_TURNOFF_BIT];
          state_nxt.chan_b.switch_mode = wb[rcrb_pkg::RCRB_SWMODE_MSB:0];
        end
        default: ;
      endcase
    end
    if (state_r.step_cnt >= step_limit) begin
      state_nxt.step_cnt = '0;
      state_nxt.step_tick = 1'b1;
    end else begin
      state_nxt.step_cnt = state_r.step_cnt + CW'(1);
      state_nxt.step_tick = 1'b0;
    end
  end

  // State register; main reset loads OTP, coin-cell reset clears backup bytes
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      state_r.chan_a <= I_OTP_DEFAULTS.chan_a;
      state_r.chan_b <= I_OTP_DEFAULTS.chan_b;
      state_r.conf_a <= I_OTP_DEFAULTS.conf_a;
      state_r.step_cnt <= '0;
      state_r.step_tick <= 1'b0;
      state_r.wr_pend <= 1'b0;
      state_r.wr_addr <= 8'h00;
      state_r.rdata <= 32'h0000_0000;
      state_r.bkp <= state_r.bkp;
      if (!I_BACKUP_CELL_POR_N) begin
        state_r.bkp <= {NBKP{rcrb_pkg::RCRB_BKP_RESET}};
      end
    end else if (!I_BACKUP_CELL_POR_N) begin
      state_r.bkp <= {NBKP{rcrb_pkg::RCRB_BKP_RESET}};
    end else if (I_CLK_EN) begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register; O_HREADYOUT and O_HRESP tied to constants
  // codes passed unchanged
  assign O_HRDATA = state_r.rdata;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_BACKUP_BYTE_A = state_r.bkp[0];
  assign O_BACKUP_BYTE_B = state_r.bkp[1];
  assign O_BACKUP_BYTE_C = state_r.bkp[2];
  assign O_BACKUP_BYTE_D = state_r.bkp[3];
  assign O_BUCK_CHANNEL_A = state_r.chan_a;
  assign O_BUCK_CHANNEL_B = state_r.chan_b;
  assign O_CHAN_A_CONF = state_r.conf_a;
  assign O_CHAN_A_STEP_TICK = state_r.step_tick;

  // Checks
  sequence wr_to(logic [7:0] a);
    addr_phase && I_HWRITE && I_HADDR[7:0] == a && I_CLK_EN;
  endsequence

  // Write address phase followed by its enabled data phase
  sequence wr_done(logic [7:0] a);
    wr_to(a) ##1 I_CLK_EN;
  endsequence

  // Read address phase accepted on an enabled edge
  sequence rd_from(logic [7:0] a);
    addr_phase && !I_HWRITE && I_HADDR[7:0] == a && I_CLK_EN;
  endsequence

  // Step counter at the last count of a period, for one rate
  sequence at_wrap(logic rate, int cyc);
    state_r.conf_a.step_rate == rate && state_r.step_cnt == CW'(cyc - 1) && I_CLK_EN;
  endsequence

  bkp_main_hold_a: assert property (@(posedge I_CLK_SYS)
    I_RESET && I_BACKUP_CELL_POR_N |=> $stable(state_r.bkp))
    else $error("backup bytes changed on main reset");
  bkp_coin_clear_a: assert property (@(posedge I_CLK_SYS)
    !I_BACKUP_CELL_POR_N |=> state_r.bkp == '0)
    else $error("backup bytes not cleared by coin reset");
  a_norm_write_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_to(rcrb_pkg::RCRB_OFF_A_NORM) ##1 I_CLK_EN |=> O_BUCK_CHANNEL_A.norm_code == $past(I_HWDATA[4:0]))
    else $error("normal code not written");
  a_mode_write_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_to(rcrb_pkg::RCRB_OFF_A_MODE) ##1 I_CLK_EN |=> O_BUCK_CHANNEL_A.turnoff_dest == $past(I_HWDATA[5]))
    else $error("turn-off bit not written");
  a_ilim_write_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_to(rcrb_pkg::RCRB_OFF_A_CONF) ##1 I_CLK_EN |=> O_CHAN_A_CONF.current_limit == $past(I_HWDATA[0]))
    else $error("current limit not written");
  b_stby_write_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_to(rcrb_pkg::RCRB_OFF_B_STBY) ##1 I_CLK_EN |=> O_BUCK_CHANNEL_B.stby_code == $past(I_HWDATA[4:0]))
    else $error("channel B standby code not written");
  otp_load_a: assert property (@(posedge I_CLK_SYS)
    I_RESET |=> O_BUCK_CHANNEL_B == $past(I_OTP_DEFAULTS.chan_b))
    else $error("OTP default not loaded");
  read_back_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    addr_phase && !I_HWRITE && I_HADDR[7:0] == rcrb_pkg::RCRB_OFF_A_STBY && I_CLK_EN
    |=> O_HRDATA == {27'h0, $past(state_r.chan_a.stby_code)})
    else $error("standby code read back wrong");
  step_gap_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET || !I_CLK_EN)
    $rose(O_CHAN_A_STEP_TICK) |=> !O_CHAN_A_STEP_TICK [*7])
    else $error("step ticks too close");

  a_stby_write_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_done(rcrb_pkg::RCRB_OFF_A_STBY) |=> O_BUCK_CHANNEL_A.stby_code == $past(I_HWDATA[4:0]))
    else $error("standby code not written");

  a_sleep_write_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_done(rcrb_pkg::RCRB_OFF_A_SLEEP) |=> O_BUCK_CHANNEL_A.sleep_code == $past(I_HWDATA[4:0]))
    else $error("sleep code not written");

  a_swmode_write_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_done(rcrb_pkg::RCRB_OFF_A_MODE) |=> O_BUCK_CHANNEL_A.switch_mode == $past(I_HWDATA[3:0]))
    else $error("switching mode not written");

  a_rate_write_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_done(rcrb_pkg::RCRB_OFF_A_CONF) |=> O_CHAN_A_CONF.step_rate == $past(I_HWDATA[6]))
    else $error("step rate not written");

  a_phase_write_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_done(rcrb_pkg::RCRB_OFF_A_CONF) |=> O_CHAN_A_CONF.clock_phase == $past(I_HWDATA[5:4]))
    else $error("clock phase not written");

  a_freq_write_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_done(rcrb_pkg::RCRB_OFF_A_CONF) |=> O_CHAN_A_CONF.switch_freq == $past(I_HWDATA[3:2]))
    else $error("switching frequency not written");

  b_norm_write_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_done(rcrb_pkg::RCRB_OFF_B_NORM) |=> O_BUCK_CHANNEL_B.norm_code == $past(I_HWDATA[4:0]))
    else $error("channel B normal code not written");

  b_sleep_write_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_done(rcrb_pkg::RCRB_OFF_B_SLEEP) |=> O_BUCK_CHANNEL_B.sleep_code == $past(I_HWDATA[4:0]))
    else $error("channel B sleep code not written");

  b_mode_write_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_done(rcrb_pkg::RCRB_OFF_B_MODE) |=> O_BUCK_CHANNEL_B.turnoff_dest == $past(I_HWDATA[5])
    && O_BUCK_CHANNEL_B.switch_mode == $past(I_HWDATA[3:0]))
    else $error("channel B mode not written");

  bkp_write_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    wr_done(rcrb_pkg::RCRB_OFF_BKP_D) |=> O_BACKUP_BYTE_D == $past(I_HWDATA[7:0]))
    else $error("backup byte not written");

  bkp_read_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    rd_from(rcrb_pkg::RCRB_OFF_BKP_C) |=> O_HRDATA == {24'h000000, $past(O_BACKUP_BYTE_C)})
    else $error("backup byte read back wrong");

  mode_read_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    rd_from(rcrb_pkg::RCRB_OFF_A_MODE) |=> O_HRDATA[5] == $past(O_BUCK_CHANNEL_A.turnoff_dest))
    else $error("turn-off bit read back wrong");

  conf_read_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    rd_from(rcrb_pkg::RCRB_OFF_A_CONF) |=> O_HRDATA[0] == $past(O_CHAN_A_CONF.current_limit))
    else $error("current limit read back wrong");

  read_upper_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    addr_phase && I_CLK_EN |=> O_HRDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  otp_a_load_a: assert property (@(posedge I_CLK_SYS)
    I_RESET |=> O_BUCK_CHANNEL_A == $past(I_OTP_DEFAULTS.chan_a))
    else $error("channel A OTP default not loaded");

  otp_conf_load_a: assert property (@(posedge I_CLK_SYS)
    I_RESET |=> O_CHAN_A_CONF == $past(I_OTP_DEFAULTS.conf_a))
    else $error("configuration OTP default not loaded");

  coin_keeps_regs_a: assert property (@(posedge I_CLK_SYS)
    !I_BACKUP_CELL_POR_N && !I_RESET |=> $stable(O_BUCK_CHANNEL_A) && $stable(O_CHAN_A_CONF))
    else $error("regulator setting changed on coin reset");

  freeze_hold_a: assert property (@(posedge I_CLK_SYS)
    !I_CLK_EN && !I_RESET && I_BACKUP_CELL_POR_N |=> $stable(O_BUCK_CHANNEL_B)
    && $stable(O_BACKUP_BYTE_A) && $stable(O_CHAN_A_STEP_TICK) && $stable(O_HRDATA))
    else $error("state changed while clock enable low");

  idle_keep_a: assert property (@(posedge I_CLK_SYS)
    !state_r.wr_pend && !I_RESET |=> $stable(O_BUCK_CHANNEL_A) && $stable(O_BUCK_CHANNEL_B)
    && $stable(O_CHAN_A_CONF))
    else $error("regulator setting changed without a write");

  fast_tick_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    at_wrap(1'b0, STEP_FAST_CYC) |=> O_CHAN_A_STEP_TICK)
    else $error("fast step tick missing");

  slow_skip_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    at_wrap(1'b1, STEP_FAST_CYC) |=> !O_CHAN_A_STEP_TICK)
    else $error("slow rate ticked at fast period");

  slow_tick_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_RESET || !I_BACKUP_CELL_POR_N)
    at_wrap(1'b1, STEP_SLOW_CYC) |=> O_CHAN_A_STEP_TICK)
    else $error("slow step tick missing");

endmodule

// ### verification/tb_rcrb_top.sv
/*
  Self-checking bench for the regulator configuration register bank.
  Assumes the design's zero-wait AHB-Lite slave and the package offsets.
*/
`timescale 1ns/100ps
module tb_rcrb_top;
  localparam int FAST = 8;
  localparam int SLOW = 16;
  logic clk, rst, clk_en, coin_n, hsel, hwrite, hready, hresp, tick;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] bk_a, bk_b, bk_c, bk_d;
  rcrb_pkg::rcrb_otp_t otp;
  rcrb_pkg::rcrb_chan_t ch_a, ch_b;
  rcrb_pkg::rcrb_conf_t conf;
  int n_fail, n_checks;
  logic [7:0] addr_t [14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
    8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h3c};
  logic [7:0] mask_t [14] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h1f, 8'h1f, 8'h2f,
    8'h7d, 8'h1f, 8'h1f, 8'h1f, 8'h2f, 8'h00};

  rcrb_top #(.STEP_FAST_CYC(FAST), .STEP_SLOW_CYC(SLOW)) i_rcrb_top (
    .I_CLK_SYS(clk), .I_RESET(rst), .I_CLK_EN(clk_en), .I_BACKUP_CELL_POR_N(coin_n),
    .I_OTP_DEFAULTS(otp), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_BACKUP_BYTE_A(bk_a),
    .O_BACKUP_BYTE_B(bk_b), .O_BACKUP_BYTE_C(bk_c), .O_BACKUP_BYTE_D(bk_d),
    .O_BUCK_CHANNEL_A(ch_a), .O_BUCK_CHANNEL_B(ch_b), .O_CHAN_A_CONF(conf),
    .O_CHAN_A_STEP_TICK(tick));

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for the slave to be ready at an edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_fail++;
        results();
      end
      @(posedge clk);
    end
  endtask

  // One single-word transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic do_reset(input logic main, input logic coin);
    rst <= main;
    coin_n <= ~coin;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    coin_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic t_defaults;
    logic [31:0] d;
    chk({12'h0, ch_a}, {12'h0, otp.chan_a});
    chk({12'h0, ch_b}, {12'h0, otp.chan_b});
    ahb(1'b0, rcrb_pkg::RCRB_OFF_A_CONF, 32'h0, d);
    chk(d, {25'h0, otp.conf_a[5:1], 1'b0, otp.conf_a[0]});
    ahb(1'b0, rcrb_pkg::RCRB_OFF_B_MODE, 32'h0, d);
    chk(d, {26'h0, otp.chan_b.turnoff_dest, 1'b0, otp.chan_b.switch_mode});
    chk({bk_a, bk_b, bk_c, bk_d}, 32'h0);
    $display("test defaults done");
  endtask

  task automatic t_rw(input logic [7:0] v);
    logic [31:0] d;
    for (int i = 0; i < 14; i++) ahb(1'b1, addr_t[i], {24'hffffff, v}, d);
    for (int i = 0; i < 14; i++) begin
      ahb(1'b0, addr_t[i], 32'h0, d);
      chk(d, {24'h0, v & mask_t[i]});
    end
    chk({12'h0, ch_a}, {12'h0, v[4:0], v[4:0], v[4:0], v[5], v[3:0]});
    chk({12'h0, ch_b}, {12'h0, v[4:0], v[4:0], v[4:0], v[5], v[3:0]});
    chk({26'h0, conf}, {26'h0, v[6:2], v[0]});
    chk({bk_a, bk_b, bk_c, bk_d}, {4{v}});
    $display("test read write %h done", v);
  endtask

  task automatic t_backup;
    do_reset(1'b1, 1'b0);
    chk({bk_a, bk_b, bk_c, bk_d}, 32'h5a5a5a5a);
    chk({12'h0, ch_a}, {12'h0, otp.chan_a});
    do_reset(1'b0, 1'b1);
    chk({bk_a, bk_b, bk_c, bk_d}, 32'h0);
    chk({12'h0, ch_b}, {12'h0, otp.chan_b});
    $display("test backup done");
  endtask

  task automatic t_tick(input logic rate, input int per);
    logic [31:0] d;
    int n;
    ahb(1'b1, rcrb_pkg::RCRB_OFF_A_CONF, {25'h0, rate, 6'h0}, d);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      @(posedge clk);
      while (tick !== 1'b1) begin
        n++;
        if (n > 100) begin
          n_fail++;
          results();
        end
        @(posedge clk);
      end
    end
    chk(n + 1, per);
    $display("test tick rate %0d done", rate);
  endtask

  task automatic t_freeze;
    logic [31:0] d;
    int n;
    n = 0;
    clk_en <= 1'b0;
    ahb(1'b1, rcrb_pkg::RCRB_OFF_BKP_A, 32'h0000_00c3, d);
    repeat (40) begin
      @(posedge clk);
      if (tick === 1'b1) n++;
    end
    chk(n, 0);
    chk({24'h000000, bk_a}, 32'h0);
    clk_en <= 1'b1;
    @(posedge clk);
    $display("test freeze done");
  endtask

  initial begin
    n_fail = 0;
    n_checks = 0;
    {rst, coin_n, clk_en, hsel, hwrite} = 5'b10100;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    otp = {5'h0b, 5'h12, 5'h04, 1'b1, 4'h6, 5'h15, 5'h09, 5'h1e, 1'b0, 4'h3, 6'h35};
    @(posedge clk);
    do_reset(1'b1, 1'b1);
    t_defaults();
    t_rw(8'ha5);
    t_rw(8'h5a);
    t_backup();
    t_tick(1'b0, FAST);
    t_tick(1'b1, SLOW);
    t_freeze();
    results();
  end
endmodule
